// >>> hw/gpio_audio_defs.svh
/*
  Constants for the general-purpose and local audio pin-sharing block:
  pin slot positions, widths and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef GPIO_AUDIO_DEFS_SVH
`define GPIO_AUDIO_DEFS_SVH

// ----------------------------------------------------------------------
// Pin slots
// ----------------------------------------------------------------------
`define GA_PIN_CNT 12
`define GA_GP_PIN_ONE 0
`define GA_GP_PIN_TWO 1
`define GA_GP_PIN_THREE 2
`define GA_GP_PIN_NINE 3
`define GA_FAST_BASE 4
`define GA_FAST_CNT 4
`define GA_REG_ONLY_PIN_5 8
`define GA_REG_ONLY_PIN_6 9
`define GA_REG_ONLY_PIN_7 10
`define GA_REG_ONLY_PIN_8 11
`define GA_AUDIO_DATA_CNT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
// Plain pins drive low, fast pins float
`define GA_GP_OE_RST 12'hF0F
`define GA_GP_OUT_RST 12'h000
`define GA_FAST_SPI_RST 4'h0

`endif

// >>> hw/gpio_audio_pkg.sv
/*
  Types for the pin-sharing block: configuration, pin bus and function
  sources. Assumes gpio_audio_defs.svh is on the include path.
*/
`default_nettype none
`include "gpio_audio_defs.svh"

package gpio_audio_pkg;

  // ----------------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    AUD_OFF,
    AUD_SLAVE,
    AUD_MASTER
  } audio_mode_t;

  typedef struct packed {
    audio_mode_t audio_mode;
    logic gp9_mclk;
    logic [`GA_FAST_CNT-1:0] fast_spi;
    logic [`GA_PIN_CNT-1:0] gp_oe;
    logic [`GA_PIN_CNT-1:0] gp_out;
  } pin_cfg_t;

  typedef struct packed {
    logic [`GA_PIN_CNT-1:0] out;
    logic [`GA_PIN_CNT-1:0] oe;
  } pin_bus_t;

  typedef struct packed {
    logic mclk;
    logic slave_word_clock;
    logic slave_bit_clock;
    logic [`GA_AUDIO_DATA_CNT-1:0] slave_data;
    logic master_word_clock;
  } audio_src_t;

  typedef struct packed {
    logic [`GA_FAST_CNT-1:0] out;
    logic [`GA_FAST_CNT-1:0] oe;
  } spi_src_t;

endpackage : gpio_audio_pkg

`default_nettype wire

// >>> hw/gpio_audio_pin_sharing.sv
/*
  Pin function selection for the plain, fast and register-only
  general-purpose pins and their audio and serial-port alternates.
  Assumes config writes, audio and serial-port sources on i_core_clk;
  pins and the power-down input arrive asynchronously.
*/
`default_nettype none
`include "gpio_audio_defs.svh"

// Behaviour
// R1 - Pin nine comes up as a general-purpose pin driving low and carries master clock only when selected.
// R2 - The four fast pins float after reset until configured.
// R3 - The fast pins work only in dual-link mode and float otherwise.
// R4 - Fast pins 0 to 3 switch to serial-port data out, data in, clock and select by configuration.
// R5 - Register-only pins 5 to 8 follow configuration alone and drive low after reset; slave audio mode drives them from the audio sources instead.
// R6 - Slave audio puts the word clock on register-only pin 7.
// R7 - Slave audio puts data a, b, c, d on register-only pins 6 and 5 and pins two and three.
// R8 - The host disables the audio jitter cleaner before using the slave bit clock pin.
// R9 - Master audio puts the master word clock on pin one.
// R10 - Pin nine can carry the audio master system clock when selected.
// R11 - Power-down low resets all selections and floats every pin; release restores defaults.
// R12 - Each pin has exactly one function driving it at a time.
module gpio_audio_pin_sharing (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Power-down pin, low powers down
  input wire logic i_power_down_n,
  // Configuration from the register file
  input wire logic i_cfg_we,
  input wire gpio_audio_pkg::pin_cfg_t i_cfg,
  input wire logic i_dual_link,
  // Alternate function sources
  input wire gpio_audio_pkg::audio_src_t i_audio,
  input wire gpio_audio_pkg::spi_src_t i_spi,
  // Pins
  input wire logic [`GA_PIN_CNT-1:0] i_pin_in,
  output var gpio_audio_pkg::pin_bus_t o_pin,
  // Status
  output var logic [`GA_PIN_CNT-1:0] o_pin_in,
  output var gpio_audio_pkg::pin_cfg_t o_cfg,
  output var logic o_powered
);
  import gpio_audio_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic pd_held;
    logic [`GA_PIN_CNT-1:0] in_meta;
    logic [`GA_PIN_CNT-1:0] in_sync;
    pin_cfg_t cfg;
    pin_bus_t pin;
  } state_t;

  localparam pin_cfg_t CFG_RST = '{
    audio_mode: AUD_OFF,
    gp9_mclk: 1'b0,
    fast_spi: `GA_FAST_SPI_RST,
    gp_oe: `GA_GP_OE_RST,
    gp_out: `GA_GP_OUT_RST
  };

  localparam state_t STATE_RST = '{
    pd_meta: 1'b0,
    pd_sync: 1'b0,
    pd_held: 1'b0,
    in_meta: '0,
    in_sync: '0,
    cfg: CFG_RST,
    pin: '0
  };

  state_t q;
  state_t d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    // Two flops before anything reads the pins
    d.pd_meta = i_power_down_n;
    d.pd_sync = q.pd_meta;
    // Powered for two cycles in a row, for the checks below
    d.pd_held = q.pd_sync;
    d.in_meta = i_pin_in;
    d.in_sync = q.in_meta;

    // Writes while powered down are dropped, not queued
    if (!q.pd_sync) begin
      d.cfg = CFG_RST; // R11
    end else if (i_cfg_we) begin
      d.cfg = i_cfg;
    end

    // Plain general-purpose function by default
    d.pin.out = q.cfg.gp_out; // R5
    d.pin.oe = q.cfg.gp_oe; // R1 R2

    for (int i = 0; i < `GA_FAST_CNT; i++) begin
      if (!i_dual_link) begin
        d.pin.out[`GA_FAST_BASE + i] = 1'b0; // R3
        d.pin.oe[`GA_FAST_BASE + i] = 1'b0; // R3
      end else if (q.cfg.fast_spi[i]) begin
        d.pin.out[`GA_FAST_BASE + i] = i_spi.out[i]; // R4
        d.pin.oe[`GA_FAST_BASE + i] = i_spi.oe[i]; // R4
      end
    end

    // One source per pin; the audio mode overrides the plain function
    case (q.cfg.audio_mode)
      AUD_SLAVE: begin
        d.pin.out[`GA_REG_ONLY_PIN_7] = i_audio.slave_word_clock; // R6
        d.pin.out[`GA_REG_ONLY_PIN_8] = i_audio.slave_bit_clock; // R8
        d.pin.out[`GA_REG_ONLY_PIN_6] = i_audio.slave_data[0]; // R7
        d.pin.out[`GA_REG_ONLY_PIN_5] = i_audio.slave_data[1]; // R7
        d.pin.out[`GA_GP_PIN_TWO] = i_audio.slave_data[2]; // R7
        d.pin.out[`GA_GP_PIN_THREE] = i_audio.slave_data[3]; // R7
        d.pin.oe[`GA_REG_ONLY_PIN_7] = 1'b1; // R12
        d.pin.oe[`GA_REG_ONLY_PIN_8] = 1'b1;
        d.pin.oe[`GA_REG_ONLY_PIN_6] = 1'b1;
        d.pin.oe[`GA_REG_ONLY_PIN_5] = 1'b1;
        d.pin.oe[`GA_GP_PIN_TWO] = 1'b1;
        d.pin.oe[`GA_GP_PIN_THREE] = 1'b1;
      end
      AUD_MASTER: begin
        d.pin.out[`GA_GP_PIN_ONE] = i_audio.master_word_clock; // R9
        d.pin.oe[`GA_GP_PIN_ONE] = 1'b1; // R12
      end
      default: begin
      end
    endcase

    if (q.cfg.gp9_mclk) begin
      d.pin.out[`GA_GP_PIN_NINE] = i_audio.mclk; // R10
      d.pin.oe[`GA_GP_PIN_NINE] = 1'b1; // R1
    end

    // Everything floats while powered down
    if (!q.pd_sync) begin
      d.pin = '0; // R11
    end

    if (i_reset) begin
      d = STATE_RST;
    end
  end

  always_ff @(posedge i_core_clk) begin
    q <= d;
  end

  assign o_pin = q.pin;
  assign o_pin_in = q.in_sync;
  assign o_cfg = q.cfg;
  assign o_powered = q.pd_sync;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  logic run;
  assign run = q.pd_sync && q.pd_held;

  property p_gp9_default;
    run && !$past(q.cfg.gp9_mclk) |->
      o_pin.out[`GA_GP_PIN_NINE] == $past(q.cfg.gp_out[`GA_GP_PIN_NINE]);
  endproperty
  a_gp9_default: assert property (p_gp9_default) else $error("pin nine not plain"); // R1

  property p_fast_float;
    !i_dual_link ##1 run |-> o_pin.oe[`GA_FAST_BASE+:`GA_FAST_CNT] == 4'h0;
  endproperty
  a_fast_float: assert property (p_fast_float) else $error("fast pin driven"); // R3

  property p_fast_spi;
    i_dual_link && q.cfg.fast_spi[0] && q.pd_sync ##1 run |->
      o_pin.out[`GA_FAST_BASE] == $past(i_spi.out[0]) &&
      o_pin.oe[`GA_FAST_BASE] == $past(i_spi.oe[0]);
  endproperty
  a_fast_spi: assert property (p_fast_spi) else $error("serial port not routed"); // R4

  property p_cfg_default;
    !q.pd_sync ##1 q.pd_sync |-> q.cfg == CFG_RST;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not default"); // R11

  property p_float_down;
    !q.pd_sync |=> o_pin.oe == 12'h000;
  endproperty
  a_float_down: assert property (p_float_down) else $error("pin driven in power-down"); // R11

  property p_slave_wc;
    q.pd_sync && q.cfg.audio_mode == AUD_SLAVE ##1 run |->
      o_pin.oe[`GA_REG_ONLY_PIN_7] &&
      o_pin.out[`GA_REG_ONLY_PIN_7] == $past(i_audio.slave_word_clock);
  endproperty
  a_slave_wc: assert property (p_slave_wc) else $error("word clock missing"); // R6

  property p_slave_data;
    q.pd_sync && q.cfg.audio_mode == AUD_SLAVE ##1 run |->
      {o_pin.out[`GA_REG_ONLY_PIN_6], o_pin.out[`GA_REG_ONLY_PIN_5],
       o_pin.out[`GA_GP_PIN_TWO], o_pin.out[`GA_GP_PIN_THREE]} ==
      {$past(i_audio.slave_data[0]), $past(i_audio.slave_data[1]),
       $past(i_audio.slave_data[2]), $past(i_audio.slave_data[3])};
  endproperty
  a_slave_data: assert property (p_slave_data) else $error("audio data misrouted"); // R7

  property p_master_wc;
    q.pd_sync && q.cfg.audio_mode == AUD_MASTER ##1 run |->
      o_pin.oe[`GA_GP_PIN_ONE] &&
      o_pin.out[`GA_GP_PIN_ONE] == $past(i_audio.master_word_clock);
  endproperty
  a_master_wc: assert property (p_master_wc) else $error("master word clock missing"); // R9

  property p_mclk;
    q.pd_sync && q.cfg.gp9_mclk ##1 run |->
      o_pin.oe[`GA_GP_PIN_NINE] && o_pin.out[`GA_GP_PIN_NINE] == $past(i_audio.mclk);
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock missing"); // R10

  property p_reg_only;
    q.pd_sync && q.cfg.audio_mode != AUD_SLAVE ##1 run |->
      o_pin.out[`GA_REG_ONLY_PIN_5+:4] == $past(q.cfg.gp_out[`GA_REG_ONLY_PIN_5+:4]);
  endproperty
  a_reg_only: assert property (p_reg_only) else $error("register-only pin wrong"); // R5

  c_power_up: cover property (!q.pd_sync ##1 q.pd_sync ##2 o_pin.oe == `GA_GP_OE_RST);
  c_slave: cover property (run && q.cfg.audio_mode == AUD_SLAVE);
  c_master: cover property (run && q.cfg.audio_mode == AUD_MASTER);
  c_spi: cover property (run && i_dual_link && q.cfg.fast_spi == 4'hF);

endmodule : gpio_audio_pin_sharing

`default_nettype wire

// >>> tb/gpio_audio_far_end.sv
/*
  Far-side model: audio codec clocks, host serial-port logic and pin loads.
  Assumes it shares the block's clock and reset.
*/
`default_nettype none
`include "gpio_audio_defs.svh"

module gpio_audio_far_end (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Pins
  input wire gpio_audio_pkg::pin_bus_t i_pin,
  output var logic [`GA_PIN_CNT-1:0] o_level,
  // Sources
  output var gpio_audio_pkg::audio_src_t o_audio,
  output var gpio_audio_pkg::spi_src_t o_spi
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_audio_pkg::*;

  logic [7:0] cnt_q;

  // Sources move every cycle so a stale pin shows
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h1D;
    end
  end

  assign o_audio = audio_src_t'(cnt_q);
  assign o_spi = spi_src_t'(~{cnt_q[3:0], cnt_q[7:4]});
  // Weak pull-down wins on any released pin
  assign o_level = i_pin.out & i_pin.oe;
endmodule : gpio_audio_far_end

`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench for the pin-sharing block.
  Assumes the package and the far-end model are compiled first.
*/
`default_nettype none
`include "gpio_audio_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_audio_pkg::*;

  localparam pin_cfg_t DEF_CFG = '{AUD_OFF, 1'b0, `GA_FAST_SPI_RST, `GA_GP_OE_RST,
                                  `GA_GP_OUT_RST};
  logic core_clk;
  logic reset;
  logic power_down_n;
  logic cfg_we;
  logic dual_link;
  logic chk_on;
  logic powered;
  pin_cfg_t cfg;
  pin_cfg_t cfg_m;
  pin_cfg_t cfg_seen;
  pin_cfg_t c;
  audio_src_t audio;
  spi_src_t spi;
  pin_bus_t pin;
  pin_bus_t exp_q;
  logic [`GA_PIN_CNT-1:0] level;
  logic [`GA_PIN_CNT-1:0] pin_in;
  int miscompares;
  int cmp_count;

  gpio_audio_pin_sharing i_gpio_audio_pin_sharing (
    .i_core_clk(core_clk), .i_reset(reset), .i_power_down_n(power_down_n),
    .i_cfg_we(cfg_we), .i_cfg(cfg), .i_dual_link(dual_link), .i_audio(audio),
    .i_spi(spi), .i_pin_in(level), .o_pin(pin), .o_pin_in(pin_in), .o_cfg(cfg_seen),
    .o_powered(powered));
  gpio_audio_far_end i_gpio_audio_far_end (
    .i_core_clk(core_clk), .i_reset(reset), .i_pin(pin), .o_level(level),
    .o_audio(audio), .o_spi(spi));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Drop of the strobe and next raise never share an edge
  task automatic write_cfg(input pin_cfg_t v);
    cfg <= v;
    cfg_we <= 1'b1;
    @(posedge core_clk);
    cfg_we <= 1'b0;
    cfg_m = v;
    tick(1);
  endtask : write_cfg

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  function automatic pin_bus_t expect_pin(pin_cfg_t k, logic dl, audio_src_t a, spi_src_t s);
    pin_bus_t r;
    r.out = k.gp_out;
    r.oe = k.gp_oe;
    for (int i = 0; i < `GA_FAST_CNT; i++) begin
      r.oe[`GA_FAST_BASE+i] = dl & (k.fast_spi[i] ? s.oe[i] : k.gp_oe[`GA_FAST_BASE+i]);
      r.out[`GA_FAST_BASE+i] = k.fast_spi[i] ? s.out[i] : k.gp_out[`GA_FAST_BASE+i];
    end
    if (k.audio_mode == AUD_SLAVE) begin
      r.out[11:8] = {a.slave_bit_clock, a.slave_word_clock, a.slave_data[0], a.slave_data[1]};
      r.out[2:1] = {a.slave_data[3], a.slave_data[2]};
      r.oe[11:8] = 4'hF;
      r.oe[2:1] = 2'h3;
    end
    if (k.audio_mode == AUD_MASTER) begin
      r.out[0] = a.master_word_clock;
      r.oe[0] = 1'b1;
    end
    if (k.gp9_mclk) begin
      r.out[3] = a.mclk;
      r.oe[3] = 1'b1;
    end
    return r;
  endfunction : expect_pin

  // ----------------------------------------------------------------------
  // Clock, per-cycle pin check, watchdog
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    if (chk_on) begin
      check("pin oe", exp_q.oe, pin.oe);
      check("pin out", exp_q.out & exp_q.oe, pin.out & pin.oe);
    end
    exp_q = expect_pin(cfg_m, dual_link, audio, spi);
  end

  // Whole run is under a hundred cycles
  initial begin
    tick(3000);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    power_down_n = 1'b1;
    cfg_we = 1'b0;
    cfg = DEF_CFG;
    dual_link = 1'b0;
    chk_on = 1'b0;
    cfg_m = DEF_CFG;
    miscompares = 0;
    cmp_count = 0;
    tick(20);
    reset <= 1'b0;
    tick(4);
    @(negedge core_clk);
    check("default oe", {20'h0, `GA_GP_OE_RST}, pin.oe);
    check("default out", 32'h0, pin.out & pin.oe);
    check("powered", 32'h1, powered);
    chk_on = 1'b1;
    tick(1);
    c = DEF_CFG;
    c.gp_oe = 12'hFFF;
    c.gp_out = 12'hA5A;
    c.fast_spi = 4'h5;
    write_cfg(c);
    tick(5);
    @(negedge core_clk);
    check("pin in", 32'hA0A, pin_in);
    tick(1);
    dual_link <= 1'b1;
    tick(6);
    c.fast_spi = 4'hA;
    write_cfg(c);
    tick(6);
    c.gp9_mclk = 1'b1;
    write_cfg(c);
    tick(6);
    c.audio_mode = AUD_SLAVE;
    write_cfg(c);
    tick(8);
    c.audio_mode = AUD_MASTER;
    write_cfg(c);
    tick(8);
    // Powered down: pins float and writes are dropped
    chk_on = 1'b0;
    power_down_n <= 1'b0;
    tick(4);
    write_cfg(c);
    @(negedge core_clk);
    check("down oe", 32'h0, pin.oe);
    check("powered down", 32'h0, powered);
    tick(1);
    power_down_n <= 1'b1;
    cfg_m = DEF_CFG;
    tick(5);
    @(negedge core_clk);
    check("cfg after power-up", DEF_CFG, cfg_seen);
    check("powered again", 32'h1, powered);
    chk_on = 1'b1;
    tick(8);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
